/* File: hdl/vgd_gate_diag.sv */
// Four-channel output gating and output-stage diagnostics
`timescale 1ns/1ps
module vgd_gate_diag
  import vgd_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire logic            rst_n,
  input  wire logic [NCH-1:0]  pwm_drive_signal,
  input  wire logic [NCH-1:0]  silent_valve_test,
  input  wire logic            hw_enable,
  input  wire logic            fast_off_all_cmd,
  input  wire logic            fast_on_permit,
  input  wire logic [NCH-1:0]  per_channel_force_on,
  input  wire logic [1:0]      oc_thresh_sel,
  input  wire logic [NCH-1:0]  status_read,
  input  wire vgd_sense_t      sense [NCH],
  output      logic [NCH-1:0]  gate_on,
  output      logic [NCH-1:0]  enable_discharge,
  output      logic [NCH-1:0]  offstate_pulldown,
  output      logic [NCH-1:0]  setpoint_zero,
  output      logic [SW-1:0]   status [NCH]
);
  logic            en_s1;
  logic            en_s2;
  vgd_sense_t      sn_s1 [NCH];
  vgd_sense_t      sn [NCH];
  logic [NCH-1:0]  fatal;
  logic [NCH-1:0]  next_gate;
  logic [NCH-1:0]  ch_on;
  logic [CW-1:0]   mux_cnt;
  logic [1:0]      mux_sel;
  logic            mux_tick;
  vgd_ch_state_t   st [NCH];

  // Enable pin and analogue comparators are asynchronous
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_s1 <= 1'b0;
      en_s2 <= 1'b0;
    end
    else
    begin
      en_s1 <= hw_enable;
      en_s2 <= en_s1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        sn_s1[i] <= '0;
        sn[i]    <= '0;
      end
    end
    else
    begin
      for (int i = 0; i < NCH; i++)
      begin
        sn_s1[i] <= sense[i];
        sn[i]    <= sn_s1[i];
      end
    end
  end

  // Gate decision; off conditions checked first so nothing can override
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      fatal[i] = (st[i] != CH_RUN);
      if (!en_s2 || fast_off_all_cmd || fatal[i])
        next_gate[i] = 1'b0;
      else if (fast_on_permit && per_channel_force_on[i])
        next_gate[i] = 1'b1;
      else if (pwm_drive_signal[i])
        next_gate[i] = 1'b1;
      else
        next_gate[i] = silent_valve_test[i] & ~pwm_drive_signal[i];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      gate_on <= '0;
    else
      gate_on <= next_gate;
  end

  // Separate discharge path; clamp conduction outranks it to save the FET
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      enable_discharge <= '0;
    else
      for (int i = 0; i < NCH; i++)
        enable_discharge[i] <= !en_s2 && !sn[i].clamp_cond;
  end

  assign ch_on = gate_on;

  // Pull-down visits each output in turn at a fixed rate
  assign mux_tick = (mux_cnt == CW'(MUX_CYC - 1));
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mux_cnt <= CNT_ZERO;
      mux_sel <= 2'b00;
    end
    else if (mux_tick)
    begin
      mux_cnt <= CNT_ZERO;
      mux_sel <= mux_sel + 2'b01;
    end
    else
      mux_cnt <= mux_cnt + 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      offstate_pulldown <= '0;
    else
      for (int i = 0; i < NCH; i++)
        // Next gate value, so the pull-down never overlaps an on gate
        offstate_pulldown[i] <= (mux_sel == 2'(i)) && !next_gate[i];
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      logic uc_hit;
      logic uc_zero;
      logic ol_hit;
      logic oc_hit;
      logic ot_hit;
      logic tw_hit;
      logic tw_zero;
      logic ot_zero;
      logic oc_cond;
      logic oc_thr_hi;
      logic opl_up;
      logic rd;
      logic uc_rep;
      logic svt_latch;

      assign rd = status_read[g];
      assign oc_thr_hi = (g < 2) ? oc_thresh_sel[g % 2] : 1'b0;
      assign oc_cond = ch_on[g] &&
        (oc_thr_hi ? sn[g].cur_over_hi : sn[g].cur_over_lo);
      // Openload sampled only while pull-down sits on this output;
      // between visits the debounce keeps its verdict
      assign opl_up = offstate_pulldown[g] ? sn[g].openld_low
                                           : ol_hit;

      vgd_filter #(.LIMIT(FW'(UC_MAX))) u_uc (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .up      (ch_on[g] && sn[g].cur_low),
        .clr     (1'b0),
        .hit     (uc_hit),
        .zero    (uc_zero)
      );
      vgd_filter #(.LIMIT(FW'(OPL_MAX))) u_opl (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .up      (opl_up),
        .clr     (1'b0),
        .hit     (ol_hit),
        .zero    ()
      );
      vgd_filter #(.LIMIT(FW'(OL_CYC))) u_oc (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .up      (oc_cond),
        .clr     (!ch_on[g]),
        .hit     (oc_hit),
        .zero    ()
      );
      // Temperature only filtered while on; an off output lets it decay
      vgd_filter #(.LIMIT(FW'(OT_CYC))) u_ot (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .up      (ch_on[g] ? sn[g].temp_sd : 1'b0),
        .clr     (1'b0),
        .hit     (ot_hit),
        .zero    (ot_zero)
      );
      vgd_filter #(.LIMIT(FW'(TW_CYC))) u_tw (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .up      (ch_on[g] ? sn[g].temp_warn : 1'b0),
        .clr     (1'b0),
        .hit     (tw_hit),
        .zero    (tw_zero)
      );

      // Undercurrent tracking: follows filter unless seen in valve test
      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          uc_rep    <= 1'b0;
          svt_latch <= 1'b0;
        end
        else
        begin
          if (uc_hit)
            uc_rep <= 1'b1;
          else if (uc_zero)
            uc_rep <= 1'b0;
          if (uc_hit && silent_valve_test[g])
            svt_latch <= 1'b1;
          else if (rd)
            svt_latch <= 1'b0;
        end
      end

      // Fault state; a read leaves trip even during a set, while in wait a set wins over release
      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
          st[g] <= CH_RUN;
        else
          case (st[g])
            CH_RUN:
              if (oc_hit || ot_hit)
                st[g] <= CH_TRIP;
            CH_TRIP:
              if (rd)
                st[g] <= CH_WAIT;
            CH_WAIT:
              if (oc_hit || ot_hit)
                st[g] <= CH_TRIP;
              else if (ot_zero && !status[g][B_OC] &&
                       !status[g][B_TSD])
                st[g] <= CH_RUN;
            default:
              st[g] <= CH_RUN;
          endcase
      end

      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
          setpoint_zero[g] <= 1'b0;
        else
          setpoint_zero[g] <= (st[g] != CH_RUN);
      end

      // Status word; every hardware set outranks the read clear
      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
          status[g] <= '0;
        else
        begin
          status[g][B_GHI] <= sn[g].gate_hi_cmp ||
                              (status[g][B_GHI] && !rd);
          status[g][B_GLO] <= sn[g].gate_lo_cmp ||
                              (status[g][B_GLO] && !rd);
          status[g][B_CLAMP] <= sn[g].clamp_cond ||
                                (status[g][B_CLAMP] && !rd);
          status[g][B_OPL] <= ol_hit || (status[g][B_OPL] && !rd);
          status[g][B_UC]  <= uc_rep || svt_latch;
          status[g][B_OC]  <= oc_hit || (status[g][B_OC] && !rd);
          status[g][B_TSD] <= ot_hit ||
                              (status[g][B_TSD] && !(rd && ot_zero));
          status[g][B_TW]  <= tw_hit ||
                              (status[g][B_TW] && !(rd && tw_zero));
          status[g][4]     <= 1'b0;
        end
      end

      AST_OFF_FAST: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (fast_off_all_cmd || fatal[g]) |=> !gate_on[g])
        else $error("gate on during forced off");
      AST_FAST_OFF_ALL_CMD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        fast_off_all_cmd |=> (gate_on == '0))
        else $error("fast off did not clear all gates");
      AST_RUN_PWM: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (en_s2 && !fast_off_all_cmd && !fatal[g] && !fast_on_permit)
        |=> (gate_on[g] == $past(pwm_drive_signal[g] ||
                                 silent_valve_test[g])))
        else $error("gate not following drive");
      AST_FORCE_ON: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (en_s2 && !fast_off_all_cmd && !fatal[g] && fast_on_permit &&
         per_channel_force_on[g]) |=> gate_on[g])
        else $error("force on ignored");
      AST_GHI_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (sn[g].gate_hi_cmp) |=> status[g][B_GHI])
        else $error("gate high not latched");
      AST_RD_CLR: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (rd && !sn[g].gate_hi_cmp && !sn[g].gate_lo_cmp)
        |=> (!status[g][B_GHI] && !status[g][B_GLO]))
        else $error("read did not clear gate history");
      AST_OC_TRIP: assert property (@(posedge sys_clk) disable iff (!rst_n)
        oc_hit |=> (st[g] == CH_TRIP && status[g][B_OC]) ##1 !gate_on[g])
        else $error("overload did not trip");
      AST_TRIP_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (st[g] == CH_TRIP && !rd) |=> st[g] == CH_TRIP)
        else $error("trip released without read");
    end
  endgenerate
endmodule

/* File: hdl/vgd_pkg.sv */
// Constants and types for the valve output gate and diagnostics block
// Summary of operation
// - Enabled, no fast-off, no fault: gate follows PWM
// - PWM drive overrides silent valve test request
// - Enable low, fast-off or fatal flag forces off
// - Fast-off-all command shuts all four outputs
// - Latch gate-high-seen at status bit 6
// - Latch gate-low-seen at status bit 7
// - Status read clears both gate history bits
// - Latch clamp-active flag when clamp conducts
// - Only clamp path outranks the enable discharge
// - Fast-on permit plus force-on turns channel on
// - Undercurrent counter up when on and low
// - Reported undercurrent clears when counter hits zero
// - Undercurrent follows filter, latched during valve test
// - Pull-down multiplexed per output at 125kHz
// - Openload debounced, bit D0, cleared on read
// - Overcurrent filtered 20us while on, shuts output
// - Overload keeps channel off until status read
// - Overcurrent bit latched, cleared by status read
// - Outputs one and two select overcurrent threshold
// - Temperature evaluated only while output on
// - Thermal warning sets D8, read clears after cooling
// - Overtemp filtered 40us, off until cool and read
package vgd_pkg;
  localparam int NCH = 4;
  localparam int CLK_MHZ = 250;
  localparam int OL_FILT_NS = 20000;
  localparam int OT_FILT_NS = 40000;
  localparam int TW_FILT_NS = 40000;
  localparam int OL_CYC = OL_FILT_NS * CLK_MHZ / 1000;
  localparam int OT_CYC = OT_FILT_NS * CLK_MHZ / 1000;
  localparam int TW_CYC = TW_FILT_NS * CLK_MHZ / 1000;
  localparam int MUX_HZ = 125000;
  localparam int MUX_CYC = CLK_MHZ * 1000000 / MUX_HZ;
  localparam int UC_MAX = 255;
  localparam int OPL_MAX = 15;
  localparam int FW = 14;
  localparam int CW = 11;
  localparam logic [FW-1:0] FILT_ZERO = 14'h0000;
  localparam logic [CW-1:0] CNT_ZERO = 11'h000;
  localparam int B_OPL = 0;
  localparam int B_UC = 1;
  localparam int B_OC = 2;
  localparam int B_TSD = 3;
  localparam int B_CLAMP = 5;
  localparam int B_GHI = 6;
  localparam int B_GLO = 7;
  localparam int B_TW = 8;
  localparam int SW = 9;
  typedef struct packed {
    logic gate_hi_cmp;
    logic gate_lo_cmp;
    logic clamp_cond;
    logic cur_low;
    logic cur_over_lo;
    logic cur_over_hi;
    logic temp_warn;
    logic temp_sd;
    logic openld_low;
  } vgd_sense_t;
  typedef enum logic [1:0] {
    CH_RUN  = 2'b00,
    CH_TRIP = 2'b01,
    CH_WAIT = 2'b10
  } vgd_ch_state_t;
endpackage

/* File: hdl/vgd_filter.sv */
// Saturating up/down debounce counter with threshold flag
`timescale 1ns/1ps
module vgd_filter
  import vgd_pkg::*;
#(
  parameter logic [FW-1:0] LIMIT = 14'h0010
)
(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic up,
  input  wire logic clr,
  output      logic hit,
  output      logic zero
);
  logic [FW-1:0] cnt;

  // Counts up on condition, down otherwise; clr forces zero
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt <= FILT_ZERO;
    else if (clr)
      cnt <= FILT_ZERO;
    else if (up && cnt != LIMIT)
      cnt <= cnt + 1'b1;
    else if (!up && cnt != FILT_ZERO)
      cnt <= cnt - 1'b1;
  end

  assign hit  = (cnt == LIMIT);
  assign zero = (cnt == FILT_ZERO);
endmodule

/* File: dv/vgd_stage_model.sv */
// Output stage model: gate comparators and injected analog faults
`timescale 1ns/1ps
module vgd_stage_model
  import vgd_pkg::*;
(
  input  wire logic           sys_clk,
  input  wire logic [NCH-1:0] gate_on,
  input  wire vgd_sense_t     fault [NCH],
  output      vgd_sense_t     sense [NCH]
);
  // Gate voltage lags the drive one cycle, as a real gate charge would
  always_ff @(posedge sys_clk)
  begin
    for (int i = 0; i < NCH; i++)
    begin
      sense[i] <= vgd_sense_t'(fault[i] | {gate_on[i], !gate_on[i], 7'h00});
    end
  end
endmodule

/* File: dv/test_vgd_gate_diag.sv */
// Self-checking bench for the gate and diagnostics block
`timescale 1ns/1ps
module test_vgd_gate_diag;
  import vgd_pkg::*;
  logic           sys_clk;
  logic           rst_n;
  logic           hw_enable;
  logic           fast_off_all_cmd;
  logic           fast_on_permit;
  logic [1:0]     oc_thresh_sel;
  logic [NCH-1:0] pwm_drive_signal;
  logic [NCH-1:0] silent_valve_test;
  logic [NCH-1:0] per_channel_force_on;
  logic [NCH-1:0] status_read;
  logic [NCH-1:0] gate_on;
  logic [NCH-1:0] enable_discharge;
  logic [NCH-1:0] offstate_pulldown;
  logic [NCH-1:0] setpoint_zero;
  logic [SW-1:0]  status [NCH];
  vgd_sense_t     sense [NCH];
  vgd_sense_t     fault [NCH];
  int             n_fail;
  int             n_tests;
  int             cyc;

  vgd_gate_diag i_vgd_gate_diag (
    .sys_clk(sys_clk), .rst_n(rst_n), .pwm_drive_signal(pwm_drive_signal),
    .silent_valve_test(silent_valve_test), .hw_enable(hw_enable),
    .fast_off_all_cmd(fast_off_all_cmd), .fast_on_permit(fast_on_permit),
    .per_channel_force_on(per_channel_force_on),
    .oc_thresh_sel(oc_thresh_sel), .status_read(status_read),
    .sense(sense), .gate_on(gate_on), .enable_discharge(enable_discharge),
    .offstate_pulldown(offstate_pulldown), .setpoint_zero(setpoint_zero),
    .status(status)
  );
  vgd_stage_model i_vgd_stage_model (
    .sys_clk(sys_clk), .gate_on(gate_on), .fault(fault), .sense(sense)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic chk(input string nm, input logic [8:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Read pulse lasts exactly one cycle, as the host access does
  task automatic rd(input int ch);
    @(posedge sys_clk);
    status_read <= 4'h1 << ch;
    @(posedge sys_clk);
    status_read <= 4'h0;
  endtask

  task automatic t_gate();
    @(posedge sys_clk);
    pwm_drive_signal <= 4'ha;
    tick(4);
    chk("gate pwm", 9'(gate_on), 9'h00a);
    hw_enable <= 1'b0;
    tick(7);
    chk("gate en low", 9'(gate_on), 9'h000);
    chk("discharge en low", 9'(enable_discharge), 9'h00f);
    hw_enable <= 1'b1;
    fast_on_permit <= 1'b1;
    per_channel_force_on <= 4'h5;
    pwm_drive_signal <= 4'h0;
    tick(7);
    chk("gate force", 9'(gate_on), 9'h005);
    fast_off_all_cmd <= 1'b1;
    tick(3);
    chk("gate fast off", 9'(gate_on), 9'h000);
    fast_off_all_cmd <= 1'b0;
    fast_on_permit <= 1'b0;
    tick(3);
    chk("gate no permit", 9'(gate_on), 9'h000);
  endtask

  task automatic t_hist();
    @(posedge sys_clk);
    pwm_drive_signal <= 4'h2;
    tick(10);
    rd(1);
    tick(8);
    chk("hist on", 9'(status[1][B_GLO:B_GHI]), 9'h001);
    pwm_drive_signal <= 4'h0;
    tick(3);
    rd(1);
    tick(8);
    chk("hist off", 9'(status[1][B_GLO:B_GHI]), 9'h002);
    repeat (6)
    begin
      pwm_drive_signal <= pwm_drive_signal ^ 4'h2;
      tick(2);
    end
    tick(6);
    chk("hist pwm", 9'(status[1][B_GLO:B_GHI]), 9'h003);
  endtask

  task automatic t_clamp();
    @(posedge sys_clk);
    fault[3].clamp_cond <= 1'b1;
    hw_enable <= 1'b0;
    tick(6);
    chk("clamp flag", 9'(status[3][B_CLAMP]), 9'h001);
    chk("clamp discharge", 9'(enable_discharge), 9'h007);
    fault[3].clamp_cond <= 1'b0;
    hw_enable <= 1'b1;
    tick(4);
    rd(3);
    tick(3);
    chk("clamp read", 9'(status[3][B_CLAMP]), 9'h000);
  endtask

  task automatic t_pulldown();
    logic [NCH-1:0] seen;
    int             bad;
    seen = 4'h0;
    bad = 0;
    @(posedge sys_clk);
    pwm_drive_signal <= 4'h1;
    fault[2].openld_low <= 1'b1;
    tick(4);
    repeat (4 * MUX_CYC + 200)
    begin
      @(posedge sys_clk);
      seen = seen | offstate_pulldown;
      if (!$onehot0(offstate_pulldown) || (offstate_pulldown & gate_on))
        bad++;
    end
    chk("pulldown seen", 9'(seen), 9'h00e);
    chk("pulldown clash", 9'(bad), 9'h000);
    chk("openload set", 9'(status[2][B_OPL]), 9'h001);
    fault[2].openld_low <= 1'b0;
    tick(4 * MUX_CYC);
    rd(2);
    tick(4);
    chk("openload read", 9'(status[2][B_OPL]), 9'h000);
  endtask

  task automatic t_under();
    @(posedge sys_clk);
    pwm_drive_signal <= 4'h2;
    fault[1].cur_low <= 1'b1;
    tick(UC_MAX + 40);
    chk("uc set", 9'(status[1][B_UC]), 9'h001);
    pwm_drive_signal <= 4'h0;
    tick(UC_MAX + 40);
    chk("uc clear", 9'(status[1][B_UC]), 9'h000);
    silent_valve_test <= 4'h2;
    tick(UC_MAX + 40);
    chk("svt gate", 9'(gate_on[1]), 9'h001);
    chk("svt uc set", 9'(status[1][B_UC]), 9'h001);
    silent_valve_test <= 4'h0;
    tick(UC_MAX + 40);
    chk("svt uc latched", 9'(status[1][B_UC]), 9'h001);
    rd(1);
    tick(3);
    chk("svt uc read", 9'(status[1][B_UC]), 9'h000);
    fault[1].cur_low <= 1'b0;
  endtask

  // Shutdown and warning together; release needs cooling and a read
  task automatic t_therm();
    @(posedge sys_clk);
    pwm_drive_signal <= 4'h8;
    fault[3].temp_sd <= 1'b1;
    fault[3].temp_warn <= 1'b1;
    tick(OT_CYC + 50);
    chk("tsd bit", 9'(status[3][B_TSD]), 9'h001);
    chk("tw bit", 9'(status[3][B_TW]), 9'h001);
    chk("tsd gate", 9'(gate_on[3]), 9'h000);
    chk("tsd zero", 9'(setpoint_zero[3]), 9'h001);
    fault[3].temp_sd <= 1'b0;
    fault[3].temp_warn <= 1'b0;
    rd(3);
    tick(10);
    chk("tsd hot read", 9'(status[3][B_TSD]), 9'h001);
    chk("tw hot read", 9'(status[3][B_TW]), 9'h001);
    tick(OT_CYC + 50);
    chk("tsd cool held", 9'(gate_on[3]), 9'h000);
    rd(3);
    tick(10);
    chk("tsd clear", 9'(status[3][B_TSD]), 9'h000);
    chk("tw clear", 9'(status[3][B_TW]), 9'h000);
    chk("tsd release", 9'(gate_on[3]), 9'h001);
    pwm_drive_signal <= 4'h0;
    tick(4);
  endtask

  // Low threshold fault on a channel; sel picks the high one for channel 0 only
  task automatic t_over(input int ch, input logic sel, input logic exp);
    @(posedge sys_clk);
    oc_thresh_sel <= {1'b0, sel};
    pwm_drive_signal <= 4'h1 << ch;
    fault[ch].cur_over_lo <= 1'b1;
    tick(OL_CYC + 50);
    chk("oc bit", 9'(status[ch][B_OC]), 9'(exp));
    chk("oc gate", 9'(gate_on[ch]), 9'(!exp));
    chk("oc zero", 9'(setpoint_zero[ch]), 9'(exp));
    fault[ch].cur_over_lo <= 1'b0;
    tick(20);
    chk("oc held", 9'(gate_on[ch]), 9'(!exp));
    rd(ch);
    tick(10);
    chk("oc read", 9'(status[ch][B_OC]), 9'h000);
    chk("oc release", 9'(gate_on[ch]), 9'h001);
    pwm_drive_signal <= 4'h0;
    tick(4);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Longest path is about 48000 cycles; the ceiling leaves ample margin
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      n_fail++;
      end_of_test();
    end
  end

  initial
  begin
    n_fail = 0;
    n_tests = 0;
    cyc = 0;
    rst_n = 1'b0;
    hw_enable = 1'b1;
    fast_off_all_cmd = 1'b0;
    fast_on_permit = 1'b0;
    oc_thresh_sel = 2'h0;
    pwm_drive_signal = 4'h0;
    silent_valve_test = 4'h0;
    per_channel_force_on = 4'h0;
    status_read = 4'h0;
    for (int i = 0; i < NCH; i++)
      fault[i] = vgd_sense_t'(9'h000);
    tick(20);
    rst_n <= 1'b1;
    tick(4);
    t_gate();
    t_hist();
    t_clamp();
    t_pulldown();
    t_under();
    t_over(2, 1'b0, 1'b1);
    t_over(0, 1'b1, 1'b0);
    t_therm();
    end_of_test();
  end
endmodule
